// >>> afs_consts.vh
`ifndef AFS_CONSTS_VH
`define AFS_CONSTS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define AFS_CLK_PERIOD_NS 100
`define AFS_CONV_TIME_NS 400
`define AFS_CONV_CYCLES ((`AFS_CONV_TIME_NS + `AFS_CLK_PERIOD_NS - 1) / `AFS_CLK_PERIOD_NS)
`define AFS_AC_PERIOD_DEF 20
// ----------------------------------------
// frame layout
// ----------------------------------------
`define AFS_RES_W 19
`define AFS_FRAME_MAX 32
`define AFS_BITS_BASE 6'h10
`define AFS_BITS_STATUS 6'h08
`define AFS_CMD_W 5
`define AFS_CMD_REGCFG 5'h1A
`endif

// >>> afs_shifter.v
module afs_shifter (
    // clock and reset
    input wire clk,
    input wire reset,
    // control
    input wire load,
    input wire [31:0] frame_word,
    input wire [5:0] frame_bits,
    input wire dual,
    input wire fall,
    input wire rise,
    input wire cs_active,
    input wire sdi_s,
    input wire extra_clock_output_state,
    // outputs
    output reg sdo0_r,
    output reg sdo1_r,
    output reg sdo_oe_r,
    output reg [4:0] cmd_r,
    output reg cmd_done_r
);
    reg [31:0] sh_r;
    reg [5:0] left_r;
    reg [2:0] cmd_cnt_r;

    // ----------------------------------------
    // output shifting on falling edges
    // ----------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sh_r <= 32'h0000_0000;
            left_r <= 6'h00;
            sdo0_r <= 1'b0;
            sdo1_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (load) begin
            sh_r <= frame_word;
            left_r <= frame_bits;
            sdo0_r <= frame_word[31];
            sdo1_r <= frame_word[30];
            sdo_oe_r <= 1'b1;
        end else if (!cs_active) begin
            sdo_oe_r <= 1'b0;
        end else if (fall) begin
            if (left_r > (dual ? 6'd2 : 6'd1)) begin
                // dual mode moves two bits per clock
                sh_r <= dual ? {sh_r[29:0], 2'b00} : {sh_r[30:0], 1'b0};
                sdo0_r <= dual ? sh_r[29] : sh_r[30];
                sdo1_r <= dual ? sh_r[28] : 1'b0;
                left_r <= left_r - (dual ? 6'd2 : 6'd1);
            end else begin
                left_r <= 6'h00;
                // extra clocks hold or release
                if (extra_clock_output_state)
                    sdo_oe_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // command capture on rising edges
    // ----------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_r <= 5'h00;
            cmd_cnt_r <= 3'h0;
            cmd_done_r <= 1'b0;
        end else begin
            cmd_done_r <= 1'b0;
            if (!cs_active) begin
                cmd_cnt_r <= 3'h0;
            end else if (rise && cmd_cnt_r < 3'd5) begin
                cmd_r <= {cmd_r[3:0], sdi_s};
                cmd_cnt_r <= cmd_cnt_r + 3'd1;
                if (cmd_cnt_r == 3'd4)
                    cmd_done_r <= 1'b1;
            end
        end
    end
endmodule

// >>> afs_frame_sync.v
`include "afs_consts.vh"
// What this block does
// - four-wire mode 3 slave port
// - busy held through whole oversampled result
// - alert updated at conversion end
// - autocycle uses internal convert timer
// - autocycle busy low end, high start
// - alert sets only on threshold violation
// - result held until next conversion
// - clocks equal bits over output lines
// - dual mode outputs two bits per clock
// - frame length from oversampling and status
// - ratio one gives 16 or 24 bits
// - sample on convert edge, ignore in config
// - extra clocks hold or release output
module afs_frame_sync #(
    parameter AC_PERIOD = `AFS_AC_PERIOD_DEF
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // spi pins
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    output wire sdo0,
    output wire sdo0_oe,
    // convert start pin
    input wire convert_start,
    // configuration
    input wire conv_mode_req,
    input wire autocycle_en,
    input wire dual_en,
    input wire status_en,
    input wire busy_en,
    input wire [1:0] max_osr_sel,
    input wire [1:0] osr_sel,
    input wire extra_clock_output_state,
    // converter core
    input wire [18:0] core_result,
    input wire [7:0] core_status,
    input wire threshold_hit,
    // busy / alert / second data pin
    output wire busy_alert_pin,
    output wire busy_alert_pin_oe,
    // state
    output reg conv_mode_r,
    output reg busy_r,
    output reg alert_r,
    output reg [5:0] clocks_per_frame_r
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_DONE = 3'b100;
    localparam [31:0] CONV_CYC = `AFS_CONV_CYCLES;

    reg [2:0] state_r;
    reg [1:0] sclk_s_r, cs_s_r, sdi_s_r, cnv_s_r;
    reg sclk_d_r, cnv_d_r;
    reg [7:0] conv_cnt_r;
    reg [15:0] ac_cnt_r;
    reg [5:0] os_cnt_r;
    reg [18:0] result_r;
    reg [7:0] stat_r;
    reg [5:0] bits_per_frame_r;
    reg cs_d_r;
    wire sdo0_i, sdo1_i, oe_i;
    wire [4:0] cmd;
    wire cmd_done;

    // bits needed for a given oversampling setting
    function [5:0] frame_bits_f;
        input [1:0] oversampling_ratio;
        input st;
        reg [5:0] base;
        begin
            base = (oversampling_ratio == 2'd0) ? `AFS_BITS_BASE : `AFS_BITS_BASE + `AFS_BITS_STATUS;
            frame_bits_f = st ? base + `AFS_BITS_STATUS : base;
            if (oversampling_ratio == 2'd0 && st)
                frame_bits_f = 6'd24;
        end
    endfunction

    function [5:0] osr_count_f;
        input [1:0] oversampling_ratio;
        begin
            case (oversampling_ratio)
                2'd0: osr_count_f = 6'd1;
                2'd1: osr_count_f = 6'd4;
                2'd2: osr_count_f = 6'd16;
                default: osr_count_f = 6'd63;
            endcase
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_s_r <= 2'b11;
            cs_s_r <= 2'b11;
            sdi_s_r <= 2'b00;
            cnv_s_r <= 2'b00;
            sclk_d_r <= 1'b1;
            cnv_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            sclk_s_r <= {sclk_s_r[0], sclk};
            cs_s_r <= {cs_s_r[0], cs_n};
            sdi_s_r <= {sdi_s_r[0], sdi};
            cnv_s_r <= {cnv_s_r[0], convert_start};
            sclk_d_r <= sclk_s_r[1];
            cnv_d_r <= cnv_s_r[1];
            cs_d_r <= cs_s_r[1];
        end
    end

    wire cs_active = ~cs_s_r[1];
    wire sck_fall = cs_active & sclk_d_r & ~sclk_s_r[1];
    wire sck_rise = cs_active & ~sclk_d_r & sclk_s_r[1];
    wire cs_start = cs_d_r & ~cs_s_r[1];
    // convert edge only counts in conversion mode
    wire ext_edge = conv_mode_r & ~autocycle_en & cnv_s_r[1] & ~cnv_d_r;
    // internal timer replaces the pin in autocycle
    wire ac_edge = conv_mode_r & autocycle_en & (ac_cnt_r == 16'h0000);
    wire start_conv = (ext_edge | ac_edge) & (state_r != ST_CONV);

    // ----------------------------------------
    // mode and frame length
    // ----------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_mode_r <= 1'b0;
            bits_per_frame_r <= `AFS_BITS_BASE;
            clocks_per_frame_r <= `AFS_BITS_BASE;
        end else begin
            if (cmd_done && cmd == `AFS_CMD_REGCFG)
                conv_mode_r <= 1'b0;
            else if (conv_mode_req)
                conv_mode_r <= 1'b1;
            bits_per_frame_r <= frame_bits_f(max_osr_sel, status_en);
            clocks_per_frame_r <= dual_en ? {1'b0, bits_per_frame_r[5:1]}
                                          : bits_per_frame_r;
        end
    end

    // ----------------------------------------
    // autocycle timer
    // ----------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset)
            ac_cnt_r <= 16'h0000;
        else if (!conv_mode_r || !autocycle_en)
            ac_cnt_r <= 16'h0000;
        else if (ac_cnt_r == 16'h0000)
            ac_cnt_r <= AC_PERIOD[15:0] - 16'h0001;
        else
            ac_cnt_r <= ac_cnt_r - 16'h0001;
    end

    // ----------------------------------------
    // conversion sequencing
    // ----------------------------------------
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            conv_cnt_r <= 8'h00;
            os_cnt_r <= 6'h00;
            busy_r <= 1'b0;
            alert_r <= 1'b0;
            result_r <= 19'h0_0000;
            stat_r <= 8'h00;
        end else begin
            // leaving conversion mode clears alert; a same-cycle set wins
            if (!conv_mode_r)
                alert_r <= 1'b0;
            case (state_r)
                ST_IDLE, ST_DONE: begin
                    if (!conv_mode_r) begin
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                        os_cnt_r <= 6'h00;
                    end else if (start_conv) begin
                        state_r <= ST_CONV;
                        conv_cnt_r <= CONV_CYC[7:0];
                        busy_r <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (conv_cnt_r > 8'd1) begin
                        conv_cnt_r <= conv_cnt_r - 8'd1;
                    end else begin
                        state_r <= ST_DONE;
                        alert_r <= threshold_hit ? 1'b1 : alert_r;
                        if (os_cnt_r + 6'd1 >= osr_count_f(osr_sel)) begin
                            os_cnt_r <= 6'h00;
                            busy_r <= 1'b0;
                            result_r <= core_result;
                            stat_r <= core_status;
                        end else begin
                            os_cnt_r <= os_cnt_r + 6'd1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // frame word and output pins
    // ----------------------------------------
    wire [31:0] frame_word = (max_osr_sel == 2'd0)
        ? {result_r[15:0], stat_r, 8'h00}
        : {result_r[18:0], 5'h00, stat_r};

    afs_shifter u_shift (
        .clk(clk),
        .reset(reset),
        .load(cs_start),
        .frame_word(frame_word),
        .frame_bits(bits_per_frame_r),
        .dual(dual_en),
        .fall(sck_fall),
        .rise(sck_rise),
        .cs_active(cs_active),
        .sdi_s(sdi_s_r[1]),
        .extra_clock_output_state(extra_clock_output_state),
        .sdo0_r(sdo0_i),
        .sdo1_r(sdo1_i),
        .sdo_oe_r(oe_i),
        .cmd_r(cmd),
        .cmd_done_r(cmd_done)
    );

    assign sdo0 = sdo0_i;
    assign sdo0_oe = oe_i;
    // shared pin: second data line in dual mode, else busy or alert
    assign busy_alert_pin = dual_en ? sdo1_i : (busy_en ? busy_r : alert_r);
    assign busy_alert_pin_oe = dual_en ? oe_i : 1'b1;
endmodule

// >>> afs_frame_sync_asserts.sv
module afs_frame_sync_asserts #(
    parameter int AC_PERIOD = 20
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pins
    input wire logic cs_n,
    input wire logic convert_start,
    input wire logic sdo0_oe,
    input wire logic busy_alert_pin,
    input wire logic busy_alert_pin_oe,
    // configuration
    input wire logic autocycle_en,
    input wire logic dual_en,
    input wire logic status_en,
    input wire logic busy_en,
    input wire logic [1:0] max_osr_sel,
    input wire logic [1:0] osr_sel,
    input wire logic threshold_hit,
    // state
    input wire logic conv_mode_r,
    input wire logic busy_r,
    input wire logic alert_r,
    input wire logic [5:0] clocks_per_frame_r
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // checks
    // ----
    localparam int AC_LIM = AC_PERIOD + 8;
    wire [5:0] base_bits = (max_osr_sel == 2'h0) ? 6'h10 : 6'h18;
    wire [5:0] cpf_exp = (base_bits + (status_en ? 6'h08 : 6'h00)) >> dual_en;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_one_conv;
        busy_r [*3] ##[1:3] !busy_r;
    endsequence
    AST_CPF: assert property (
        $rose(conv_mode_r) |-> ##2 clocks_per_frame_r == cpf_exp)
        else $error("frame clock count wrong");
    AST_EDGE_TAKEN: assert property (
        $rose(convert_start) && conv_mode_r && !autocycle_en && !busy_r |-> ##[1:6] busy_r)
        else $error("convert edge not taken");
    AST_CFG_IGNORED: assert property (!conv_mode_r [*8] |-> !busy_r)
        else $error("conversion in config mode");
    AST_CONV_LEN: assert property ($rose(busy_r) && osr_sel == 2'h0 |-> s_one_conv)
        else $error("busy length wrong");
    AST_OSR_HOLD: assert property ($rose(busy_r) && osr_sel == 2'h1 |-> busy_r [*8])
        else $error("busy dropped mid oversample");
    AST_AUTO_RUN: assert property (
        conv_mode_r && autocycle_en && !busy_r |-> ##[0:AC_LIM] (busy_r || !conv_mode_r))
        else $error("autocycle conversion missing");
    AST_ALERT_CAUSE: assert property ($rose(alert_r) |-> $past(threshold_hit))
        else $error("alert without violation");
    AST_PIN_MUX: assert property (
        !dual_en |-> busy_alert_pin_oe && busy_alert_pin == (busy_en ? busy_r : alert_r))
        else $error("shared pin wrong");
    AST_SDO_DRIVE: assert property ($fell(cs_n) && conv_mode_r |-> ##[1:5] sdo0_oe)
        else $error("data out not driven");
endmodule
bind afs_frame_sync afs_frame_sync_asserts #(.AC_PERIOD(AC_PERIOD)) u_chk (
    .clk, .reset, .cs_n, .convert_start, .sdo0_oe, .busy_alert_pin, .busy_alert_pin_oe,
    .autocycle_en, .dual_en, .status_en, .busy_en, .max_osr_sel, .osr_sel, .threshold_hit,
    .conv_mode_r, .busy_r, .alert_r, .clocks_per_frame_r);

// >>> afs_host_model.sv
module afs_host_model (
    // clock
    input wire logic clk,
    // spi master pins
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    // data lines, pulled up
    input wire logic sdo0,
    input wire logic sdo1
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // one frame, command bits first on sdi
    task automatic frame(input int n, input logic [4:0] cmd,
                         output logic [31:0] r0, output logic [31:0] r1);
        logic [31:0] c;
        c = {cmd, 27'h000_0000};
        r0 = 32'h0000_0000;
        r1 = 32'h0000_0000;
        @(posedge clk) cs_n <= 1'b0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            r0 = {r0[30:0], sdo0};
            r1 = {r1[30:0], sdo1};
            sclk <= 1'b0;
            sdi <= c[31];
            c = c << 1;
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
        end
        cs_n <= 1'b1;
        sdi <= ~sdi;
    endtask
endmodule

// >>> afs_frame_sync_tb.sv
`include "afs_consts.vh"
module afs_frame_sync_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic convert_start = 1'b0;
    logic conv_mode_req = 1'b0;
    logic autocycle_en = 1'b0;
    logic dual_en = 1'b0;
    logic status_en = 1'b0;
    logic busy_en = 1'b0;
    logic extra_clock_output_state = 1'b0;
    logic threshold_hit = 1'b0;
    logic [1:0] max_osr_sel = 2'h0;
    logic [1:0] osr_sel = 2'h0;
    logic [18:0] core_result = 19'h2_A5C2;
    logic [7:0] core_status = 8'h5A;
    wire sclk, cs_n, sdi, sdo0, sdo0_oe, busy_alert_pin, busy_alert_pin_oe;
    wire conv_mode_r, busy_r, alert_r;
    wire [5:0] clocks_per_frame_r;
    wire sdo_l = sdo0_oe ? sdo0 : 1'b1;
    wire pin_l = busy_alert_pin_oe ? busy_alert_pin : 1'b1;
    logic [31:0] r0, r1, e0, e1;
    int errors = 0;
    int num_checks = 0;
    always #50 clk = ~clk;
    afs_frame_sync #(.AC_PERIOD(400)) u_dut (.clk, .reset, .sclk, .cs_n, .sdi, .sdo0, .sdo0_oe,
        .convert_start, .conv_mode_req, .autocycle_en, .dual_en, .status_en, .busy_en,
        .max_osr_sel, .osr_sel, .extra_clock_output_state, .core_result, .core_status,
        .threshold_hit, .busy_alert_pin, .busy_alert_pin_oe, .conv_mode_r, .busy_r,
        .alert_r, .clocks_per_frame_r);
    afs_host_model u_host (.clk, .sclk, .cs_n, .sdi, .sdo0(sdo_l), .sdo1(pin_l));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic enter(input logic dual, input logic st, input logic [1:0] oversampling_ratio);
        conv_mode_req <= 1'b0;
        dual_en <= dual;
        status_en <= st;
        osr_sel <= oversampling_ratio;
        max_osr_sel <= oversampling_ratio;
        repeat (4) @(posedge clk);
        conv_mode_req <= 1'b1;
        @(posedge clk);
        conv_mode_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic timer_wait();
        @(posedge clk) convert_start <= 1'b1;
        repeat (4) @(posedge clk);
        cmp({31'h0, busy_r}, 32'h0000_0001);
        repeat (`AFS_CONV_CYCLES) @(posedge clk);
        convert_start <= 1'b0;
        cmp({31'h0, busy_r}, 32'h0000_0000);
    endtask
    task automatic pulse_wait();
        int k;
        k = 0;
        @(posedge clk) convert_start <= !autocycle_en;
        repeat (4) @(posedge clk);
        convert_start <= 1'b0;
        while (busy_r !== 1'b0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        cmp(32'(k < 2000), 32'h0000_0001);
    endtask
    task automatic t_cfg();
        cmp({26'h0, clocks_per_frame_r}, 32'h0000_0010);
        pulse_wait();
        cmp({30'h0, conv_mode_r, busy_r}, 32'h0000_0000);
    endtask
    task automatic t_single();
        busy_en <= 1'b1;
        enter(1'b0, 1'b0, 2'h0);
        cmp({26'h0, clocks_per_frame_r}, 32'h0000_0010);
        for (int s = 0; s < 2; s++) begin
            extra_clock_output_state <= s[0];
            pulse_wait();
            cmp({31'h0, pin_l}, 32'h0000_0000);
            u_host.frame(18, s ? 5'h1A : 5'h00, r0, r1);
            cmp(r0, {14'h0, 16'hA5C2, s[0], s[0]});
        end
        cmp({31'h0, alert_r}, 32'h0000_0000);
    endtask
    task automatic t_dual();
        logic [31:0] w;
        w = {16'hA5C2, 8'h5A, 8'h00};
        e0 = 32'h0000_0000;
        e1 = 32'h0000_0000;
        enter(1'b1, 1'b1, 2'h0);
        cmp({26'h0, clocks_per_frame_r}, 32'h0000_000C);
        timer_wait();
        u_host.frame(12, 5'h1A, r0, r1);
        for (int i = 0; i < 12; i++) begin
            e0 = {e0[30:0], w[31 - 2 * i]};
            e1 = {e1[30:0], w[30 - 2 * i]};
        end
        cmp(r0, e0);
        cmp(r1, e1);
    endtask
    task automatic t_auto();
        busy_en <= 1'b0;
        autocycle_en <= 1'b1;
        threshold_hit <= 1'b1;
        enter(1'b0, 1'b1, 2'h1);
        cmp({26'h0, clocks_per_frame_r}, 32'h0000_0020);
        pulse_wait();
        cmp({31'h0, alert_r}, 32'h0000_0001);
        cmp({31'h0, pin_l}, 32'h0000_0001);
        u_host.frame(32, 5'h1A, r0, r1);
        cmp(r0, {19'h2_A5C2, 5'h00, 8'h5A});
        cmp({31'h0, conv_mode_r}, 32'h0000_0000);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_cfg();
        t_single();
        t_dual();
        t_auto();
        end_sim();
    end
    initial begin
        #3000000;
        errors++;
        end_sim();
    end
endmodule
